// *** design/bias_cfg.svh ***
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 25 MHz core clock, 32-bit AHB-Lite register words
// Notes: shared by the temperature and top design files of the converter control
`ifndef BIAS_CFG_SVH
`define BIAS_CFG_SVH
`define CLK_MHZ 25
`define ADDR_ADC_CONV 8'h00
`define ADDR_HW_CONFIG 8'h04
`define ADDR_SW_CLEAR 8'h08
`define ADDR_CAL_CTRL 8'h0C
`define ADDR_ALARM_CFG 8'h10
`define ADDR_DAC_IN_BASE 8'h14
`define ADDR_DAC_LOAD 8'h1C
`define ADDR_DAC_DIRECT_BASE 8'h20
`define ADDR_STATUS 8'h28
`define ADDR_TEMP_LAST 8'h2C
`define CONT_BIT 7
`define TEMP_CH_MASK 7'h13
`define MON_BIT 10
`define CLK_SEL_LO 4
`define FIFO_CLEAR_BIT 2
`define CAL_GO_BIT 0
`define CAL_FOLLOW_BIT 1
`define CAL_AUTO_BIT 2
`define HW_CONFIG_RST 16'h0000
`define CKM_INT 2'h0
`define CKM_ONE 2'h1
`define CKM_EACH 2'h3
`define TEMP_PWRUP_US 50
`define TEMP_PWRUP_CYC (`TEMP_PWRUP_US * `CLK_MHZ)
`define CAL_PERIOD_US 13000
`define CAL_PERIOD_CYC (`CAL_PERIOD_US * `CLK_MHZ)
`define KELVIN_OFFSET 12'h888
`endif

// *** design/bias_pkg.sv ***
// Purpose: shared types of the converter control
// Assumes: nothing beyond the cfg header
// Notes: states are binary coded
package bias_pkg;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_ARM = 3'b001,
		S_PWRUP = 3'b010,
		S_CONV = 3'b011,
		S_CAL = 3'b100
	} scan_state_e;
	typedef logic [11:0] code_t;
	typedef logic [2:0] chan_t;
endpackage

// *** design/dac_channel.sv ***
// Purpose: double-buffered code registers of one DAC
// Assumes: write strobes are one-cycle pulses from the bus slave
// Notes: direct write updates both registers at once
`timescale 1ns/10ps
module dac_channel
	import bias_pkg::*;
(
	input wire logic clock_i,
	input wire logic srst_i,
	input wire logic in_wr_i,
	input wire logic direct_wr_i,
	input wire logic load_i,
	input wire code_t data_i,
	output code_t in_code_o,
	output code_t out_code_o
);
	// ------------------------------------------------------------
	// input and output registers
	// ------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			in_code_o <= 12'h000;
		end else if (in_wr_i || direct_wr_i) begin
			in_code_o <= data_i;
		end
	end
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			out_code_o <= 12'h000;
		end else if (direct_wr_i) begin
			out_code_o <= data_i;
		end else if (load_i) begin
			out_code_o <= in_code_o;
		end
	end
	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_dac_load: assert property (@(posedge clock_i) disable iff (srst_i)
		load_i && !direct_wr_i |=> out_code_o == $past(in_code_o))
		else $error("load did not copy input code");
	a_dac_direct: assert property (@(posedge clock_i) disable iff (srst_i)
		direct_wr_i |=> out_code_o == $past(data_i))
		else $error("direct write did not reach output code");
	a_dac_hold: assert property (@(posedge clock_i) disable iff (srst_i)
		!load_i && !direct_wr_i |=> $stable(out_code_o))
		else $error("output code changed without command");
endmodule

// *** design/temp_calc.sv ***
// Purpose: forms a Celsius temperature code from two diode samples
// Assumes: both samples taken on the internal reference
// Notes: 12-bit two's complement, three fractional bits
`timescale 1ns/10ps
`include "bias_cfg.svh"
module temp_calc
	import bias_pkg::*;
(
	input wire code_t low_i,
	input wire code_t high_i,
	output code_t temp_o
);
	// ------------------------------------------------------------
	// difference minus the Kelvin offset
	// ------------------------------------------------------------
	// wraps modulo 4096, which is the signed result
	assign temp_o = high_i - low_i - `KELVIN_OFFSET;
endmodule

// *** design/bias_converter_control.sv ***
// Purpose: converter side control of a dual bias controller
// Assumes: AHB-Lite slave with zero wait states
// Notes: analog ADC, FIFO and calibration engines sit outside
`timescale 1ns/10ps
`include "bias_cfg.svh"
module bias_converter_control
	import bias_pkg::*;
#(
	parameter int CAL_PERIOD_CYC = `CAL_PERIOD_CYC
)
(
	input wire logic clock_i,
	input wire logic srst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic convert_strobe_n_i,
	input wire logic [1:0] clamp_request_i,
	input wire logic [1:0] alarm_trip_i,
	input wire logic adc_done_i,
	input wire code_t adc_data_i,
	input wire logic cal_done_i,
	output logic adc_start_o,
	output chan_t adc_chan_o,
	output logic adc_bias_high_o,
	output logic adc_int_ref_o,
	output logic fifo_push_o,
	output logic [15:0] fifo_word_o,
	output logic fifo_clear_o,
	output code_t dac_code_a_o,
	output code_t dac_code_b_o,
	output logic [3:0] ref_sel_o,
	output logic [1:0] gate_clamp_o,
	output logic busy_o,
	output logic temp_power_o,
	output logic cal_start_o,
	output logic cal_track_o
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic chan_t first_set(input logic [6:0] m);
		first_set = 3'h0;
		for (int i = 6; i >= 0; i--) begin
			if (m[i]) begin
				first_set = chan_t'(i);
			end
		end
	endfunction

	function automatic logic is_temp(input chan_t c);
		logic [6:0] m;
		m = `TEMP_CH_MASK;
		is_temp = m[c];
	endfunction

	scan_state_e state;
	logic wr_pend;
	logic [7:0] wr_addr;
	logic [7:0] conv_reg;
	logic [15:0] hw_config;
	logic [2:0] cal_ctrl;
	logic [3:0] alarm_cfg;
	logic [6:0] pend;
	logic [11:0] pwr_cnt;
	logic temps_ready;
	code_t temp_lo;
	code_t temp_val;
	code_t temp_last;
	logic cal_req;
	logic [18:0] cal_cnt;
	logic cal_tick;
	logic strobe_meta;
	logic strobe_sync;
	logic strobe_prev;
	logic strobe_fall;
	logic [1:0] clamp_meta;
	logic [1:0] clamp_sync;
	logic conv_wr;
	logic hw_wr;
	logic software_clear_register_wr;
	logic cal_wr;
	logic alarm_wr;
	logic load_wr;
	logic [1:0] in_wr;
	logic [1:0] direct_wr;
	logic [1:0] mode;
	logic [6:0] next_pend;
	logic [31:0] read_data;
	code_t dac_in [2];
	code_t dac_out [2];

	assign mode = hw_config[`CLK_SEL_LO +: 2];
	assign next_pend = pend & ~(7'h01 << adc_chan_o);

	// ------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else begin
			wr_pend <= hsel_i && htrans_i[1] && hwrite_i && hready_i;
			if (hsel_i && htrans_i[1] && hready_i) begin
				wr_addr <= haddr_i[7:0];
			end
		end
	end

	always_ff @(posedge clock_i) begin
		hreadyout_o <= 1'b1;
		hresp_o <= 1'b0;
	end

	always_comb begin
		conv_wr = wr_pend && (wr_addr == `ADDR_ADC_CONV);
		hw_wr = wr_pend && (wr_addr == `ADDR_HW_CONFIG);
		software_clear_register_wr = wr_pend && (wr_addr == `ADDR_SW_CLEAR);
		cal_wr = wr_pend && (wr_addr == `ADDR_CAL_CTRL);
		alarm_wr = wr_pend && (wr_addr == `ADDR_ALARM_CFG);
		load_wr = wr_pend && (wr_addr == `ADDR_DAC_LOAD);
	end

	always_comb begin
		read_data = 32'h0000_0000;
		unique case (haddr_i[7:0])
			`ADDR_ADC_CONV: read_data[7:0] = conv_reg;
			`ADDR_HW_CONFIG: read_data[15:0] = hw_config;
			`ADDR_CAL_CTRL: read_data[2:0] = cal_ctrl;
			`ADDR_ALARM_CFG: read_data[3:0] = alarm_cfg;
			`ADDR_DAC_IN_BASE: read_data[11:0] = dac_in[0];
			8'h18: read_data[11:0] = dac_in[1];
			`ADDR_DAC_DIRECT_BASE: read_data[11:0] = dac_out[0];
			8'h24: read_data[11:0] = dac_out[1];
			`ADDR_STATUS: read_data[7:0] = {state, temp_power_o,
				cal_req, busy_o, gate_clamp_o};
			`ADDR_TEMP_LAST: read_data[11:0] = temp_last;
			default: read_data = 32'h0000_0000;
		endcase
	end

	// read data is sampled in the address phase, so a read right
	// behind a write to the same word sees the old value
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			hrdata_o <= 32'h0000_0000;
		end else if (hsel_i && htrans_i[1] && !hwrite_i && hready_i) begin
			hrdata_o <= read_data;
		end
	end

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			conv_reg <= 8'h00;
			hw_config <= `HW_CONFIG_RST;
			cal_ctrl <= 3'h0;
			alarm_cfg <= 4'h0;
		end else begin
			if (conv_wr) begin
				conv_reg <= hwdata_i[7:0];
			end
			if (hw_wr) begin
				hw_config <= hwdata_i[15:0];
			end
			if (cal_wr) begin
				cal_ctrl <= hwdata_i[2:0];
			end
			if (alarm_wr) begin
				alarm_cfg <= hwdata_i[3:0];
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			ref_sel_o <= 4'h0;
			fifo_clear_o <= 1'b0;
		end else begin
			ref_sel_o <= hw_config[3:0];
			fifo_clear_o <= software_clear_register_wr && hwdata_i[`FIFO_CLEAR_BIT];
		end
	end

	// ------------------------------------------------------------
	// DAC channels
	// ------------------------------------------------------------
	for (genvar g = 0; g < 2; g++) begin : g_dac
		assign in_wr[g] = wr_pend &&
			(wr_addr == `ADDR_DAC_IN_BASE + 8'(4 * g));
		assign direct_wr[g] = wr_pend &&
			(wr_addr == `ADDR_DAC_DIRECT_BASE + 8'(4 * g));
		dac_channel u_dac (
			.clock_i(clock_i),
			.srst_i(srst_i),
			.in_wr_i(in_wr[g]),
			.direct_wr_i(direct_wr[g]),
			.load_i(load_wr && hwdata_i[g]),
			.data_i(hwdata_i[11:0]),
			.in_code_o(dac_in[g]),
			.out_code_o(dac_out[g])
		);
	end
	assign dac_code_a_o = dac_out[0];
	assign dac_code_b_o = dac_out[1];

	// ------------------------------------------------------------
	// pin synchronisers and clamp
	// ------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			strobe_meta <= 1'b1;
			strobe_sync <= 1'b1;
			strobe_prev <= 1'b1;
			clamp_meta <= 2'h0;
			clamp_sync <= 2'h0;
		end else begin
			strobe_meta <= convert_strobe_n_i;
			strobe_sync <= strobe_meta;
			strobe_prev <= strobe_sync;
			clamp_meta <= clamp_request_i;
			clamp_sync <= clamp_meta;
		end
	end
	assign strobe_fall = strobe_prev && !strobe_sync;

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			gate_clamp_o <= 2'h0;
		end else begin
			gate_clamp_o <= clamp_sync | alarm_cfg[1:0] |
				(alarm_cfg[3:2] & alarm_trip_i);
		end
	end

	// ------------------------------------------------------------
	// self-calibration requests
	// ------------------------------------------------------------
	// auto repeat only runs in follow mode with go and timer set
	assign cal_tick = (&cal_ctrl) &&
		(cal_cnt == 19'(CAL_PERIOD_CYC - 1));

	always_ff @(posedge clock_i) begin
		if (srst_i || !(&cal_ctrl)) begin
			cal_cnt <= 19'h00000;
		end else if (cal_tick) begin
			cal_cnt <= 19'h00000;
		end else begin
			cal_cnt <= cal_cnt + 19'h00001;
		end
	end

	// a new request wins over the clear of the one being started
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			cal_req <= 1'b0;
		end else if ((cal_wr && hwdata_i[`CAL_GO_BIT]) || cal_tick) begin
			cal_req <= 1'b1;
		end else if (state == S_CAL) begin
			cal_req <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// conversion scan sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			state <= S_IDLE;
			pend <= 7'h00;
			pwr_cnt <= 12'h000;
			adc_start_o <= 1'b0;
			adc_chan_o <= 3'h0;
			adc_bias_high_o <= 1'b0;
			adc_int_ref_o <= 1'b1;
			cal_start_o <= 1'b0;
			cal_track_o <= 1'b0;
			temp_lo <= 12'h000;
		end else begin
			adc_start_o <= 1'b0;
			cal_start_o <= 1'b0;
			if (conv_wr && state != S_CAL) begin
				pend <= hwdata_i[6:0];
				adc_bias_high_o <= 1'b0;
				pwr_cnt <= 12'h000;
				if (hwdata_i[6:0] == 7'h00) begin
					state <= S_IDLE;
				end else if (mode == `CKM_INT) begin
					state <= S_PWRUP;
				end else begin
					state <= S_ARM;
				end
			end else begin
				unique case (state)
					S_IDLE: begin
						if (cal_req) begin
							state <= S_CAL;
							cal_start_o <= 1'b1;
							cal_track_o <= cal_ctrl[`CAL_FOLLOW_BIT];
						end else if (conv_reg[`CONT_BIT] &&
							conv_reg[6:0] != 7'h00 && mode == `CKM_INT) begin
							pend <= conv_reg[6:0];
							state <= S_PWRUP;
						end
					end
					S_ARM: begin
						if (strobe_fall) begin
							state <= S_PWRUP;
						end
					end
					S_PWRUP: begin
						if (pend == 7'h00) begin
							state <= S_IDLE;
						end else if (!(|(pend & `TEMP_CH_MASK)) || temps_ready) begin
							adc_start_o <= 1'b1;
							adc_chan_o <= first_set(pend);
							adc_int_ref_o <= is_temp(first_set(pend)) ||
								hw_config[1:0] == 2'h0;
							state <= S_CONV;
							pwr_cnt <= 12'h000;
						end else begin
							pwr_cnt <= pwr_cnt + 12'h001;
						end
					end
					S_CONV: begin
						if (adc_done_i) begin
							if (is_temp(adc_chan_o) && !adc_bias_high_o) begin
								temp_lo <= adc_data_i;
								adc_bias_high_o <= 1'b1;
								adc_start_o <= 1'b1;
							end else begin
								adc_bias_high_o <= 1'b0;
								pend <= next_pend;
								if (next_pend == 7'h00) begin
									state <= S_IDLE;
								end else if (mode == `CKM_EACH) begin
									state <= S_ARM;
								end else begin
									adc_start_o <= 1'b1;
									adc_chan_o <= first_set(next_pend);
									adc_int_ref_o <=
										is_temp(first_set(next_pend)) ||
										hw_config[1:0] == 2'h0;
								end
							end
						end
					end
					S_CAL: begin
						if (cal_done_i) begin
							state <= S_IDLE;
						end
					end
					default: state <= S_IDLE;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// temperature sensor power and results
	// ------------------------------------------------------------
	// sensors stay up across the scan to skip the per-channel settle
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			temp_power_o <= 1'b0;
			temps_ready <= 1'b0;
		end else if (state == S_PWRUP && |(pend & `TEMP_CH_MASK)) begin
			temp_power_o <= 1'b1;
			if (pwr_cnt == 12'(`TEMP_PWRUP_CYC - 1)) begin
				temps_ready <= 1'b1;
			end
		end else if (state == S_IDLE && !(conv_reg[`CONT_BIT] &&
			|(conv_reg[6:0] & `TEMP_CH_MASK))) begin
			temp_power_o <= 1'b0;
			temps_ready <= 1'b0;
		end
	end

	temp_calc u_temp (
		.low_i(temp_lo),
		.high_i(adc_data_i),
		.temp_o(temp_val)
	);

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			fifo_push_o <= 1'b0;
			fifo_word_o <= 16'h0000;
			temp_last <= 12'h000;
		end else begin
			fifo_push_o <= 1'b0;
			if (state == S_CONV && adc_done_i &&
				(!is_temp(adc_chan_o) || adc_bias_high_o)) begin
				fifo_push_o <= hw_config[`MON_BIT];
				fifo_word_o <= {1'b0, adc_chan_o,
					is_temp(adc_chan_o) ? temp_val : adc_data_i};
				if (is_temp(adc_chan_o)) begin
					temp_last <= temp_val;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// busy
	// ------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			busy_o <= 1'b0;
		end else begin
			busy_o <= ((state == S_PWRUP || state == S_CONV) &&
				!conv_reg[`CONT_BIT]) || state == S_CAL;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (srst_i);

	a_busy_scan: assert property (
		state == S_CONV && !conv_reg[`CONT_BIT] |=> busy_o)
		else $error("busy low during a scan");
	a_cal_end: assert property (
		state == S_CAL && cal_done_i && !cal_req |=> ##1 !busy_o)
		else $error("busy still high after calibration");
	a_cal_hold: assert property (
		state == S_CAL |=> !adc_start_o)
		else $error("conversion started during calibration");
	a_temp_ref: assert property (
		adc_start_o && is_temp(adc_chan_o) |-> adc_int_ref_o)
		else $error("temperature conversion off internal reference");
	a_scan_order: assert property (
		adc_start_o |->
		(pend & ((7'h01 << adc_chan_o) - 7'h01)) == 7'h00)
		else $error("channel converted out of scan order");
	a_conv_cancel: assert property (
		conv_wr && state != S_CAL |=> pend == $past(hwdata_i[6:0]))
		else $error("new command did not replace pending scan");
	a_clamp_pin: assert property (
		clamp_sync[0] |=> gate_clamp_o[0])
		else $error("clamp pin did not clamp gate");
	a_clamp_trip: assert property (
		alarm_cfg[2] && alarm_trip_i[0] |=> gate_clamp_o[0])
		else $error("alarm trip did not clamp gate");
	a_temp_power: assert property (
		temp_power_o && conv_reg[`CONT_BIT] &&
		|(conv_reg[6:0] & `TEMP_CH_MASK) |=> temp_power_o)
		else $error("sensors dropped under continuous conversion");
	a_cal_auto: assert property (
		cal_tick |=> cal_req)
		else $error("auto calibration not requested");
endmodule

// *** test/adc_model.sv ***
// Purpose: converter and calibration engine at the far side
// Assumes: one conversion in flight at a time
// Notes: data lines toggle when no result stands
`timescale 1ns/10ps
module adc_model
	import bias_pkg::*;
(
	input wire logic clock_i,
	input wire logic srst_i,
	input wire logic start_i,
	input wire logic bias_high_i,
	input wire logic cal_start_i,
	input wire code_t hi_i,
	input wire code_t lo_i,
	input wire logic [4:0] delay_i,
	output logic done_o,
	output code_t data_o,
	output logic cal_done_o
);
	int cnt;
	int ccnt;
	// --------------------------------------------------------------
	// answers
	// --------------------------------------------------------------
	// stale data is inverted so that a late sample shows up as wrong
	always @(posedge clock_i) begin
		done_o <= 1'b0;
		cal_done_o <= 1'b0;
		data_o <= ~data_o;
		if (srst_i) begin
			cnt <= 0;
			ccnt <= 0;
			data_o <= 12'hA5A;
		end else begin
			if (start_i) cnt <= delay_i + 1;
			else if (cnt > 0) cnt <= cnt - 1;
			if (!start_i && cnt == 1) begin
				done_o <= 1'b1;
				data_o <= bias_high_i ? hi_i : lo_i;
			end
			if (cal_start_i) ccnt <= 30;
			else if (ccnt > 0) ccnt <= ccnt - 1;
			if (!cal_start_i && ccnt == 1) cal_done_o <= 1'b1;
		end
	end
endmodule

// *** test/tb_top.sv ***
// Purpose: self-checking bench of the converter control
// Assumes: zero-wait bus slave, short calibration period
// Notes: random codes from a fixed seed
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
	$display("unexpected %0t got %h want %h", $time, a, b); end end
`define WT(s, v) for (k = 0; k < 3000 && s !== v; k++) \
	@(posedge clock_i); `CHK(s, v)
module tb_top;
	import bias_pkg::*;
	logic clock_i = 0;
	logic srst_i = 1;
	logic hsel_i = 0;
	logic [31:0] haddr_i = 0;
	logic [1:0] htrans_i = 0;
	logic hwrite_i = 0;
	logic [2:0] hsize_i = 3'h2;
	logic [31:0] hwdata_i = 0;
	logic convert_strobe_n_i = 1;
	logic [1:0] clamp_request_i = 0;
	logic [1:0] alarm_trip_i = 0;
	logic [4:0] delay = 5'h02;
	code_t hi = 0;
	code_t lo = 0;
	wire logic hready_i;
	logic [31:0] hrdata_o, r, d;
	logic hreadyout_o, hresp_o, adc_done_i, cal_done_i, adc_start_o;
	logic adc_bias_high_o, adc_int_ref_o, fifo_push_o, fifo_clear_o;
	logic busy_o, temp_power_o, cal_start_o, cal_track_o;
	code_t adc_data_i, dac_code_a_o, dac_code_b_o, ea, eb;
	chan_t adc_chan_o;
	logic [15:0] fifo_word_o;
	logic [3:0] ref_sel_o;
	logic [1:0] gate_clamp_o;
	logic [15:0] pq[$];
	chan_t chs[3] = '{3'h0, 3'h1, 3'h4};
	int errors = 0;
	int n_tests = 0;
	int starts = 0;
	int cals = 0;
	int k;
	assign hready_i = hreadyout_o;
	bias_converter_control #(.CAL_PERIOD_CYC(50)) u_dut (.clock_i, .srst_i,
		.hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
		.hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .convert_strobe_n_i,
		.clamp_request_i, .alarm_trip_i, .adc_done_i, .adc_data_i,
		.cal_done_i, .adc_start_o, .adc_chan_o, .adc_bias_high_o,
		.adc_int_ref_o, .fifo_push_o, .fifo_word_o, .fifo_clear_o,
		.dac_code_a_o, .dac_code_b_o, .ref_sel_o, .gate_clamp_o, .busy_o,
		.temp_power_o, .cal_start_o, .cal_track_o);
	adc_model u_adc (.clock_i, .srst_i, .start_i(adc_start_o),
		.bias_high_i(adc_bias_high_o), .cal_start_i(cal_start_o),
		.hi_i(hi), .lo_i(lo), .delay_i(delay), .done_o(adc_done_i),
		.data_o(adc_data_i), .cal_done_o(cal_done_i));
	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	always #20 clock_i = ~clock_i;
	always @(posedge clock_i) begin
		if (fifo_push_o === 1'b1) pq.push_back(fifo_word_o);
		if (adc_start_o === 1'b1) starts++;
		if (cal_start_o === 1'b1) cals++;
	end
	function automatic code_t exp_t(code_t h, code_t l);
		return h - l - 12'h888;
	endfunction
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] v);
		hsel_i <= 1'b1;
		htrans_i <= 2'h2;
		hwrite_i <= w;
		haddr_i <= {24'h000000, a};
		do @(posedge clock_i); while (hready_i !== 1'b1);
		htrans_i <= 2'h0;
		hsel_i <= 1'b0;
		hwdata_i <= v;
		do @(posedge clock_i); while (hready_i !== 1'b1);
		r = hrdata_o;
		`CHK(hresp_o, 1'b0)
	endtask
	task final_report;
		if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#(40 * 60000);
		errors++;
		final_report;
	end
	// --------------------------------------------------------------
	// scenarios
	// --------------------------------------------------------------
	initial begin
		void'($urandom(32'h1700));
		ea = 12'h000;
		eb = 12'h000;
		repeat (12) @(posedge clock_i);
		srst_i <= 1'b0;
		@(posedge clock_i);
		`CHK(adc_int_ref_o, 1'b1)
		`CHK(dac_code_a_o, ea)
		for (int i = 0; i < 4; i++) begin
			d = $urandom;
			bus(1'b1, 8'h14, d);
			repeat (2) @(posedge clock_i);
			`CHK(dac_code_a_o, ea)
			bus(1'b0, 8'h14, 32'h0);
			`CHK(r[11:0], d[11:0])
			bus(1'b1, 8'h1C, 32'h1);
			ea = d[11:0];
			repeat (2) @(posedge clock_i);
			`CHK(dac_code_a_o, ea)
			bus(1'b1, 8'h24, ~d);
			eb = ~d[11:0];
			repeat (2) @(posedge clock_i);
			`CHK(dac_code_b_o, eb)
			bus(1'b1, 8'h04, {28'h0, d[3:0]});
			repeat (2) @(posedge clock_i);
			`CHK(ref_sel_o, d[3:0])
		end
		bus(1'b0, 8'h3C, 32'h0);
		`CHK(r, 32'h00000000)
		clamp_request_i <= 2'b01;
		repeat (6) @(posedge clock_i);
		`CHK(gate_clamp_o, 2'b01)
		clamp_request_i <= 2'b00;
		repeat (6) @(posedge clock_i);
		`CHK(gate_clamp_o, 2'b00)
		bus(1'b1, 8'h10, 32'h2);
		repeat (2) @(posedge clock_i);
		`CHK(gate_clamp_o, 2'b10)
		bus(1'b1, 8'h10, 32'h4);
		alarm_trip_i <= 2'b01;
		repeat (3) @(posedge clock_i);
		`CHK(gate_clamp_o, 2'b01)
		alarm_trip_i <= 2'b00;
		bus(1'b1, 8'h10, 32'h0);
		bus(1'b1, 8'h0C, 32'h1);
		`WT(cal_start_o, 1'b1)
		@(posedge clock_i);
		`CHK(busy_o, 1'b1)
		`WT(busy_o, 1'b0)
		bus(1'b1, 8'h0C, 32'h3);
		`WT(cal_start_o, 1'b1)
		@(posedge clock_i);
		`CHK(cal_track_o, 1'b1)
		`WT(busy_o, 1'b0)
		// without the timer bit no further calibration may start
		k = cals;
		repeat (120) @(posedge clock_i);
		`CHK(cals, k)
		bus(1'b1, 8'h0C, 32'h7);
		`WT(cal_start_o, 1'b1)
		`WT(cal_start_o, 1'b0)
		`WT(cal_start_o, 1'b1)
		bus(1'b1, 8'h0C, 32'h0);
		`WT(busy_o, 1'b0)
		// external refs selected, temperature must still use internal
		bus(1'b1, 8'h04, 32'h40F);
		for (int i = 0; i < 2; i++) begin
			hi <= code_t'($urandom);
			lo <= code_t'($urandom);
			delay <= i ? 5'h14 : 5'h00;
			pq.delete();
			bus(1'b1, 8'h00, 32'h13);
			`WT(temp_power_o, 1'b1)
			`CHK(busy_o, 1'b1)
			`WT(busy_o, 1'b0)
			`CHK(pq.size(), 3)
			for (int j = 0; j < 3; j++)
				`CHK(pq[j], {1'b0, chs[j], exp_t(hi, lo)})
			`CHK(adc_int_ref_o, 1'b1)
			`CHK(temp_power_o, 1'b0)
		end
		bus(1'b1, 8'h04, 32'h410);
		bus(1'b1, 8'h00, 32'h4);
		k = starts;
		repeat (20) @(posedge clock_i);
		`CHK(starts, k)
		k = starts;
		convert_strobe_n_i <= 1'b0;
		repeat (8) @(posedge clock_i);
		convert_strobe_n_i <= 1'b1;
		repeat (4) @(posedge clock_i);
		`CHK(starts, k + 1)
		`CHK(adc_chan_o, 3'h2)
		`WT(busy_o, 1'b0)
		// mode 11: one strobe per channel, idle while armed
		bus(1'b1, 8'h04, 32'h430);
		bus(1'b1, 8'h00, 32'hC);
		k = starts;
		for (int i = 1; i < 3; i++) begin
			convert_strobe_n_i <= 1'b0;
			repeat (8) @(posedge clock_i);
			convert_strobe_n_i <= 1'b1;
			repeat (40) @(posedge clock_i);
			`CHK(starts, k + i)
			`CHK(adc_chan_o, 3'(i + 1))
		end
		`WT(busy_o, 1'b0)
		pq.delete();
		bus(1'b1, 8'h04, 32'h400);
		bus(1'b1, 8'h00, 32'h84);
		repeat (40) @(posedge clock_i);
		`CHK(busy_o, 1'b0)
		`CHK(pq.size() > 0, 1'b1)
		`CHK(pq[0], {4'h2, lo})
		bus(1'b1, 8'h00, 32'h80);
		bus(1'b1, 8'h00, 32'h0);
		bus(1'b1, 8'h04, 32'h10);
		bus(1'b1, 8'h04, 32'h0);
		bus(1'b1, 8'h08, 32'h4);
		`WT(fifo_clear_o, 1'b1)
		repeat (40) @(posedge clock_i);
		k = starts;
		repeat (40) @(posedge clock_i);
		`CHK(starts, k)
		// after the switch procedure a single conversion still runs
		d = starts + 1;
		bus(1'b1, 8'h00, 32'h4);
		`WT(starts, d)
		final_report;
	end
endmodule
